// ==== rtl/reset_cause_pkg.sv ====
// constants for the reset-cause status block and its register slave
// assumes a 32-bit AXI4-Lite bus with one aligned word per register

package reset_cause_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [31:0] OFF_STATUS   = 32'h0000_0000;
    localparam logic [31:0] OFF_IRQ_STAT = 32'h0000_0004;
    localparam logic [31:0] OFF_IRQ_MASK = 32'h0000_0008;
    localparam logic [31:0] OFF_DEPTH    = 32'h0000_000c;

    // ----------------------------------------------------------------
    // bit positions of the reset-cause status register
    // ----------------------------------------------------------------
    localparam int BIT_OVF = 7;  // stack overflow, set by hardware
    localparam int BIT_UNF = 6;  // stack underflow, set by hardware
    localparam int BIT_WWV = 5;  // watchdog window violation
    localparam int BIT_WDT = 4;  // watchdog timeout
    localparam int BIT_PIN = 3;  // external reset pin
    localparam int BIT_RI  = 2;  // reset instruction
    localparam int BIT_POR = 1;  // power-on
    localparam int BIT_BOR = 0;  // brown-out

    // ----------------------------------------------------------------
    // reset and load values
    // ----------------------------------------------------------------
    localparam logic [7:0] STATUS_RST = 8'h3d;  // power-on: por flag low
    localparam logic [7:0] BOR_HIT    = 8'hfd;  // bits a brown-out loads
    localparam logic [7:0] BOR_VAL    = 8'h3c;  // values it loads there
    localparam logic [7:0] CAUSE_VAL  = 8'hc0;  // stack flags set, rest clear
    localparam logic [7:0] MASK_RST   = 8'h00;
    localparam logic [7:0] ISTAT_RST  = 8'h00;

    // ----------------------------------------------------------------
    // return stack
    // ----------------------------------------------------------------
    localparam int         RET_AW      = 15;     // return address width
    localparam int         DEPTH_W     = 5;
    localparam logic [4:0] STACK_LEVELS = 5'h10; // sixteen levels
    localparam logic [4:0] DEPTH_ONE    = 5'h01;
    localparam logic [4:0] DEPTH_ZERO   = 5'h00;

    // ----------------------------------------------------------------
    // bus responses
    // ----------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ==== rtl/reset_cause_flags.sv ====
// reset-cause flag register with its return stack and AXI4-Lite slave
// assumes event inputs are one-cycle pulses synchronous to aclk, and
// that aresetn is asserted only by power-on; other resets arrive as events
//
// What this block does
// RULE1: sixteen-level return stack, reset on over/underflow
// RULE2: overflow sets bit 7 until firmware clears
// RULE3: underflow sets bit 6 until firmware clears
// RULE4: window violation clears bit 5, firmware sets
// RULE5: watchdog timeout clears bit 4, firmware sets
// RULE6: external pin reset clears bit 3
// RULE7: power-on clears bit 1, firmware rewrites it
// RULE8: brown-out clears bit 0, firmware rewrites it
// RULE9: power-on/brown-out load defaults, others keep them
// RULE10: reset instruction clears bit 2, firmware sets
// RULE11: firmware reads/writes flags, hardware event wins

`timescale 1ns/1ps

module reset_cause_flags (
    // clock and reset
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // return stack
    input  wire logic                 stack_push,
    input  wire logic [14:0]          push_addr,
    input  wire logic                 stack_pop,
    output logic      [14:0]          pop_addr,
    output logic                      stack_reset_req,
    // reset cause events
    input  wire logic                 wdt_window_evt,
    input  wire logic                 wdt_timeout_evt,
    input  wire logic                 ext_pin_reset_evt,
    input  wire logic                 reset_instr_evt,
    input  wire logic                 brown_out_evt,
    // interrupt
    output logic                      irq,
    // axi4-lite write address and data
    input  wire logic [31:0]          awaddr,
    input  wire logic                 awvalid,
    output logic                      awready,
    input  wire logic [31:0]          wdata,
    input  wire logic [3:0]           wstrb,
    input  wire logic                 wvalid,
    output logic                      wready,
    // axi4-lite write response
    output logic [1:0]                bresp,
    output logic                      bvalid,
    input  wire logic                 bready,
    // axi4-lite read
    input  wire logic [31:0]          araddr,
    input  wire logic                 arvalid,
    output logic                      arready,
    output logic [31:0]               rdata,
    output logic [1:0]                rresp,
    output logic                      rvalid,
    input  wire logic                 rready
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [14:0] stack_mem [0:15];
    logic [4:0]  depth_r;
    logic [14:0] pop_addr_r;
    logic        stack_req_r;
    logic [7:0]  status_r;
    logic [7:0]  status_nxt;
    logic [7:0]  istat_r;
    logic [7:0]  mask_r;
    logic        irq_r;
    logic [31:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        aw_held_r;
    logic        w_held_r;
    logic        awready_r;
    logic        wready_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        arready_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;

    // ----------------------------------------------------------------
    // hardware events
    // ----------------------------------------------------------------
    logic       ovf_evt;
    logic       unf_evt;
    logic [7:0] cause_hit;
    logic [7:0] hw_hit;
    logic [7:0] hw_val;
    logic       any_reset;

    // RULE1: stack limit detection
    // push wins when both arrive, so a pop seen with a push is dropped
    assign ovf_evt = stack_push && (depth_r == reset_cause_pkg::STACK_LEVELS);
    assign unf_evt = stack_pop && !stack_push && (depth_r == reset_cause_pkg::DEPTH_ZERO);

    // RULE2 RULE3 RULE4 RULE5 RULE6 RULE10: one bit per flag an event drives
    assign cause_hit = {ovf_evt, unf_evt, wdt_window_evt, wdt_timeout_evt,
                        ext_pin_reset_evt, reset_instr_evt, 1'b0, brown_out_evt};
    assign any_reset = |cause_hit;

    // RULE8 RULE9: brown-out loads defaults where no own cause is recorded
    assign hw_hit = cause_hit | (brown_out_evt ? reset_cause_pkg::BOR_HIT : 8'h00);
    assign hw_val = (cause_hit & reset_cause_pkg::CAUSE_VAL)
                  | (~cause_hit & reset_cause_pkg::BOR_VAL);

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    logic wr_fire;
    logic wr_status;
    logic wr_istat;
    logic wr_mask;
    logic wr_mapped;

    assign wr_fire   = aw_held_r && w_held_r && !bvalid_r;
    assign wr_status = wr_fire && wstrb_r[0] && (awaddr_r == reset_cause_pkg::OFF_STATUS);
    assign wr_istat  = wr_fire && wstrb_r[0] && (awaddr_r == reset_cause_pkg::OFF_IRQ_STAT);
    assign wr_mask   = wr_fire && wstrb_r[0] && (awaddr_r == reset_cause_pkg::OFF_IRQ_MASK);
    assign wr_mapped = (awaddr_r == reset_cause_pkg::OFF_STATUS)
                    || (awaddr_r == reset_cause_pkg::OFF_IRQ_STAT)
                    || (awaddr_r == reset_cause_pkg::OFF_IRQ_MASK)
                    || (awaddr_r == reset_cause_pkg::OFF_DEPTH);

    // ----------------------------------------------------------------
    // return stack
    // ----------------------------------------------------------------
    // RULE1: push/pop with reset on limits
    // any reset cause empties the stack, as the core restarts
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            depth_r     <= reset_cause_pkg::DEPTH_ZERO;
            pop_addr_r  <= 15'h0000;
            stack_req_r <= 1'b0;
        end else begin
            stack_req_r <= ovf_evt || unf_evt;
            if (any_reset) begin
                depth_r <= reset_cause_pkg::DEPTH_ZERO;
            end else if (stack_push) begin
                depth_r <= depth_r + reset_cause_pkg::DEPTH_ONE;
            end else if (stack_pop) begin
                depth_r    <= depth_r - reset_cause_pkg::DEPTH_ONE;
                pop_addr_r <= stack_mem[depth_r[3:0] - 4'h1];
            end
        end
    end

    // entries hold no reset value; only depth_r says which are live
    always_ff @(posedge aclk) begin
        if (stack_push && !any_reset) begin
            stack_mem[depth_r[3:0]] <= push_addr;
        end
    end

    // ----------------------------------------------------------------
    // reset-cause flags
    // ----------------------------------------------------------------
    // RULE11: hardware event beats a firmware write per bit
    always_comb begin
        status_nxt = status_r;
        if (wr_status) begin
            status_nxt = wdata_r[7:0];
        end
        status_nxt = (hw_hit & hw_val) | (~hw_hit & status_nxt);
    end

    // RULE7: power-on clears por flag and loads defaults
    // RULE9: flags survive every reset but power-on and brown-out
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_r <= reset_cause_pkg::STATUS_RST;
        end else begin
            status_r <= status_nxt;
        end
    end

    // ----------------------------------------------------------------
    // interrupt status and mask
    // ----------------------------------------------------------------
    // sticky bits, write one to clear; a new event wins over the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            istat_r <= reset_cause_pkg::ISTAT_RST;
        end else begin
            istat_r <= cause_hit | (istat_r & ~(wr_istat ? wdata_r[7:0] : 8'h00));
        end
    end

    // mask of the same layout, one enables the bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_r <= reset_cause_pkg::MASK_RST;
        end else if (wr_mask) begin
            mask_r <= wdata_r[7:0];
        end
    end

    // registered level, one cycle behind status and mask
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(istat_r & mask_r);
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite write channel
    // ----------------------------------------------------------------
    // address and data are held independently and taken in any order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b0;
            aw_held_r <= 1'b0;
            awaddr_r  <= 32'h0000_0000;
        end else if (awready_r && awvalid) begin
            awready_r <= 1'b0;
            aw_held_r <= 1'b1;
            awaddr_r  <= awaddr;
        end else begin
            if (wr_fire) begin
                aw_held_r <= 1'b0;
            end
            if (!aw_held_r && !bvalid_r) begin
                awready_r <= 1'b1;
            end
        end
    end

    // data side mirrors the address side
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_r <= 1'b0;
            w_held_r <= 1'b0;
            wdata_r  <= 32'h0000_0000;
            wstrb_r  <= 4'h0;
        end else if (wready_r && wvalid) begin
            wready_r <= 1'b0;
            w_held_r <= 1'b1;
            wdata_r  <= wdata;
            wstrb_r  <= wstrb;
        end else begin
            if (wr_fire) begin
                w_held_r <= 1'b0;
            end
            if (!w_held_r && !bvalid_r) begin
                wready_r <= 1'b1;
            end
        end
    end

    // response one cycle after both halves are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= reset_cause_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_mapped ? reset_cause_pkg::RESP_OKAY
                                  : reset_cause_pkg::RESP_SLVERR;
        end else if (bvalid_r && bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite read channel
    // ----------------------------------------------------------------
    // data captured at the address edge; reads have no side effects
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= reset_cause_pkg::RESP_OKAY;
        end else if (arready_r && arvalid) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rresp_r   <= reset_cause_pkg::RESP_OKAY;
            case (araddr)
                reset_cause_pkg::OFF_STATUS:   rdata_r <= {24'h000000, status_r};
                reset_cause_pkg::OFF_IRQ_STAT: rdata_r <= {24'h000000, istat_r};
                reset_cause_pkg::OFF_IRQ_MASK: rdata_r <= {24'h000000, mask_r};
                reset_cause_pkg::OFF_DEPTH:    rdata_r <= {27'h0000000, depth_r};
                default: begin
                    rdata_r <= 32'h0000_0000;
                    rresp_r <= reset_cause_pkg::RESP_SLVERR;
                end
            endcase
        end else begin
            if (rvalid_r && rready) begin
                rvalid_r <= 1'b0;
            end
            if (!rvalid_r) begin
                arready_r <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign pop_addr        = pop_addr_r;
    assign stack_reset_req = stack_req_r;
    assign irq             = irq_r;
    assign awready         = awready_r;
    assign wready          = wready_r;
    assign bvalid          = bvalid_r;
    assign bresp           = bresp_r;
    assign arready         = arready_r;
    assign rvalid          = rvalid_r;
    assign rdata           = rdata_r;
    assign rresp           = rresp_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_stack_over_req: assert property (@(posedge aclk) disable iff (!aresetn) // RULE1
        (stack_push && depth_r == 5'h10) |=> stack_reset_req ##1 !stack_reset_req)
        else $error("stack overflow did not raise one reset pulse");

    a_ovf_flag_set: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
        ovf_evt |=> status_r[7] && depth_r == 5'h00)
        else $error("overflow flag not set");

    a_unf_flag_set: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
        unf_evt |=> status_r[6] && stack_reset_req)
        else $error("underflow flag not set");

    a_wwv_flag_clr: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
        wdt_window_evt |=> !status_r[5] && istat_r[5])
        else $error("window violation flag not cleared");

    a_wdt_flag_clr: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
        wdt_timeout_evt |=> !status_r[4])
        else $error("watchdog timeout flag not cleared");

    a_pin_flag_clr: assert property (@(posedge aclk) disable iff (!aresetn) // RULE6
        ext_pin_reset_evt |=> !status_r[3])
        else $error("pin reset flag not cleared");

    a_por_flag_low: assert property (@(posedge aclk) // RULE7
        $rose(aresetn) |-> status_r == 8'h3d)
        else $error("power-on defaults wrong");

    a_bor_defaults: assert property (@(posedge aclk) disable iff (!aresetn) // RULE8
        (brown_out_evt && cause_hit == 8'h01)
            |=> status_r[7:2] == 6'h0f && !status_r[0]
                && status_r[1] == ($past(wr_status) ? $past(wdata_r[1]) : $past(status_r[1])))
        else $error("brown-out defaults wrong");

    a_keep_flags: assert property (@(posedge aclk) disable iff (!aresetn) // RULE9
        (!wr_status && cause_hit == 8'h00) |=> $stable(status_r))
        else $error("flags changed without cause");
    a_ri_flag_clr: assert property (@(posedge aclk) disable iff (!aresetn) // RULE10
        reset_instr_evt |=> !status_r[2])
        else $error("reset instruction flag not cleared");

    a_fw_write: assert property (@(posedge aclk) disable iff (!aresetn) // RULE11
        (wr_status && hw_hit == 8'h00) |=> status_r == $past(wdata_r[7:0]) && bvalid)
        else $error("firmware write not stored");

    a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn) // RULE11
        1'b1 |=> irq == (|($past(istat_r) & $past(mask_r))))
        else $error("interrupt level mismatch");
endmodule

// ==== dv/tb_reset_cause_flags.sv ====
// self-checking bench for the reset-cause flag block and its register slave
// assumes a lone AXI4-Lite master, one-cycle event pulses and aresetn as power-on

`timescale 1ns/1ps

module tb_reset_cause_flags;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic        aclk       = 1'b0;
    logic        aresetn    = 1'b0;
    logic        stack_push = 1'b0;
    logic        stack_pop  = 1'b0;
    logic [14:0] push_addr  = 15'h0000;
    logic [14:0] pop_addr;
    logic        stack_reset_req;
    logic [4:0]  evt        = 5'h00;
    logic        irq;
    logic [31:0] awaddr     = 32'h0000_0000;
    logic        awvalid    = 1'b0;
    logic        awready;
    logic [31:0] wdata      = 32'h0000_0000;
    logic [3:0]  wstrb      = 4'h0;
    logic        wvalid     = 1'b0;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready     = 1'b0;
    logic [31:0] araddr     = 32'h0000_0000;
    logic        arvalid    = 1'b0;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready     = 1'b0;
    int          n_mismatch   = 0;
    int          total_checks = 0;
    logic [14:0] addrs [16];
    logic [7:0]  v;

    // 50 ns period clock
    always #25 aclk = ~aclk;

    reset_cause_flags i_dut (
        .aclk              (aclk),
        .aresetn           (aresetn),
        .stack_push        (stack_push),
        .push_addr         (push_addr),
        .stack_pop         (stack_pop),
        .pop_addr          (pop_addr),
        .stack_reset_req   (stack_reset_req),
        .wdt_window_evt    (evt[0]),
        .wdt_timeout_evt   (evt[1]),
        .ext_pin_reset_evt (evt[2]),
        .reset_instr_evt   (evt[3]),
        .brown_out_evt     (evt[4]),
        .irq               (irq),
        .awaddr            (awaddr),
        .awvalid           (awvalid),
        .awready           (awready),
        .wdata             (wdata),
        .wstrb             (wstrb),
        .wvalid            (wvalid),
        .wready            (wready),
        .bresp             (bresp),
        .bvalid            (bvalid),
        .bready            (bready),
        .araddr            (araddr),
        .arvalid           (arvalid),
        .arready           (arready),
        .rdata             (rdata),
        .rresp             (rresp),
        .rvalid            (rvalid),
        .rready            (rready)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // verdict and end of run, the only exit
    task report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // upper data bits carry noise, the slave must look at the low byte only
    task automatic axi_wr(input logic [31:0] a, input logic [7:0] d, input logic [3:0] s,
                          input logic [1:0] er);
        int n;
        bit ad;
        bit wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge aclk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= ($urandom() & 32'hffff_ff00) | {24'h0, d};
        wstrb   <= s;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (!ad && awready) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wd && wready) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
            if (bvalid) begin
                check(bresp, er);
                bready <= 1'b0;
                break;
            end
        end
        if (n == 100) begin
            n_mismatch++;
            report_and_stop;
        end
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        bit ad;
        ad = 1'b0;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (!ad && arready) begin
                ad = 1'b1;
                arvalid <= 1'b0;
            end
            if (rvalid) begin
                check(rdata, e);
                check(rresp, er);
                rready <= 1'b0;
                break;
            end
        end
        if (n == 100) begin
            n_mismatch++;
            report_and_stop;
        end
    endtask

    // one-cycle cause event, index 0..4 as wired to evt
    task automatic pulse(input int k);
        @(posedge aclk);
        evt <= 5'h01 << k;
        @(posedge aclk);
        evt <= 5'h00;
    endtask

    // one stack cycle; returns just after the edge that took it
    task automatic stk(input logic pu, input logic po, input logic [14:0] a);
        @(posedge aclk);
        stack_push <= pu;
        stack_pop  <= po;
        push_addr  <= a;
        @(posedge aclk);
        stack_push <= 1'b0;
        stack_pop  <= 1'b0;
        #1;
    endtask

    // brown-out loads defaults but keeps the power-on flag; others clear one bit
    function automatic logic [7:0] exp_status(input logic [7:0] s, input int k);
        logic [7:0] r;
        r = s;
        if (k == 4) begin
            r = {2'b00, 4'hf, s[1], 1'b0};
        end else begin
            r[5 - k] = 1'b0;
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(98));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(reset_cause_pkg::OFF_STATUS, 32'h3d, reset_cause_pkg::RESP_OKAY);
        rd_chk(reset_cause_pkg::OFF_IRQ_STAT, 32'h0, reset_cause_pkg::RESP_OKAY);
        rd_chk(reset_cause_pkg::OFF_DEPTH, 32'h0, reset_cause_pkg::RESP_OKAY);
        // unmapped place refused without effect
        axi_wr(32'h40, 8'hff, 4'hf, reset_cause_pkg::RESP_SLVERR);
        rd_chk(32'h40, 32'h0, reset_cause_pkg::RESP_SLVERR);
        rd_chk(reset_cause_pkg::OFF_STATUS, 32'h3d, reset_cause_pkg::RESP_OKAY);
        axi_wr(reset_cause_pkg::OFF_STATUS, 8'h3f, 4'hf, reset_cause_pkg::RESP_OKAY);
        rd_chk(reset_cause_pkg::OFF_STATUS, 32'h3f, reset_cause_pkg::RESP_OKAY);
        // low strobe off and read-only depth leave state alone
        axi_wr(reset_cause_pkg::OFF_STATUS, 8'h00, 4'he, reset_cause_pkg::RESP_OKAY);
        rd_chk(reset_cause_pkg::OFF_STATUS, 32'h3f, reset_cause_pkg::RESP_OKAY);
        axi_wr(reset_cause_pkg::OFF_DEPTH, 8'h1f, 4'hf, reset_cause_pkg::RESP_OKAY);
        rd_chk(reset_cause_pkg::OFF_DEPTH, 32'h0, reset_cause_pkg::RESP_OKAY);
        for (int i = 0; i < 8; i++) begin
            v = 8'($urandom());
            axi_wr(reset_cause_pkg::OFF_STATUS, v, 4'hf, reset_cause_pkg::RESP_OKAY);
            rd_chk(reset_cause_pkg::OFF_STATUS, {24'h0, v}, reset_cause_pkg::RESP_OKAY);
        end
        // window, timeout, pin and reset-instruction causes, each with its interrupt raised and cleared
        axi_wr(reset_cause_pkg::OFF_IRQ_MASK, 8'hff, 4'hf, reset_cause_pkg::RESP_OKAY);
        for (int k = 0; k < 4; k++) begin
            v = 8'($urandom() & 32'h3f) | (8'h01 << (5 - k));
            axi_wr(reset_cause_pkg::OFF_STATUS, v, 4'hf, reset_cause_pkg::RESP_OKAY);
            axi_wr(reset_cause_pkg::OFF_IRQ_STAT, 8'hff, 4'hf, reset_cause_pkg::RESP_OKAY);
            pulse(k);
            rd_chk(reset_cause_pkg::OFF_STATUS, {24'h0, exp_status(v, k)}, 2'b00);
            rd_chk(reset_cause_pkg::OFF_IRQ_STAT, 32'h1 << (5 - k), 2'b00);
            check(irq, 1'b1);
            axi_wr(reset_cause_pkg::OFF_IRQ_STAT, 8'h01 << (5 - k), 4'hf, 2'b00);
            repeat (2) @(posedge aclk);
            #1;
            check(irq, 1'b0);
        end
        // masked event stays silent until unmasked
        axi_wr(reset_cause_pkg::OFF_STATUS, 8'h3f, 4'hf, reset_cause_pkg::RESP_OKAY);
        axi_wr(reset_cause_pkg::OFF_IRQ_MASK, 8'h00, 4'hf, reset_cause_pkg::RESP_OKAY);
        pulse(1);
        repeat (3) @(posedge aclk);
        #1;
        check(irq, 1'b0);
        rd_chk(reset_cause_pkg::OFF_IRQ_STAT, 32'h10, reset_cause_pkg::RESP_OKAY);
        axi_wr(reset_cause_pkg::OFF_IRQ_MASK, 8'hff, 4'hf, reset_cause_pkg::RESP_OKAY);
        repeat (3) @(posedge aclk);
        #1;
        check(irq, 1'b1);
        // fill the stack to sixteen, pop two back, refill
        axi_wr(reset_cause_pkg::OFF_STATUS, 8'h00, 4'hf, reset_cause_pkg::RESP_OKAY);
        axi_wr(reset_cause_pkg::OFF_IRQ_STAT, 8'hff, 4'hf, reset_cause_pkg::RESP_OKAY);
        for (int i = 0; i < 16; i++) begin
            addrs[i] = 15'($urandom());
            stk(1'b1, 1'b0, addrs[i]);
            check(stack_reset_req, 1'b0);
        end
        rd_chk(reset_cause_pkg::OFF_DEPTH, 32'h10, reset_cause_pkg::RESP_OKAY);
        stk(1'b0, 1'b1, 15'h0000);
        check(pop_addr, addrs[15]);
        stk(1'b0, 1'b1, 15'h0000);
        check(pop_addr, addrs[14]);
        rd_chk(reset_cause_pkg::OFF_DEPTH, 32'he, reset_cause_pkg::RESP_OKAY);
        stk(1'b1, 1'b0, addrs[14]);
        stk(1'b1, 1'b0, addrs[15]);
        // seventeenth push overflows, then a pop on empty underflows
        stk(1'b1, 1'b0, 15'($urandom()));
        check(stack_reset_req, 1'b1);
        @(posedge aclk);
        #1;
        check(stack_reset_req, 1'b0);
        rd_chk(reset_cause_pkg::OFF_STATUS, 32'h80, reset_cause_pkg::RESP_OKAY);
        rd_chk(reset_cause_pkg::OFF_DEPTH, 32'h0, reset_cause_pkg::RESP_OKAY);
        rd_chk(reset_cause_pkg::OFF_IRQ_STAT, 32'h80, reset_cause_pkg::RESP_OKAY);
        stk(1'b0, 1'b1, 15'h0000);
        check(stack_reset_req, 1'b1);
        rd_chk(reset_cause_pkg::OFF_STATUS, 32'hc0, reset_cause_pkg::RESP_OKAY);
        axi_wr(reset_cause_pkg::OFF_STATUS, 8'h3f, 4'hf, reset_cause_pkg::RESP_OKAY);
        rd_chk(reset_cause_pkg::OFF_STATUS, 32'h3f, reset_cause_pkg::RESP_OKAY);
        // brown-out loads defaults and keeps the power-on flag
        axi_wr(reset_cause_pkg::OFF_STATUS, 8'hc2, 4'hf, reset_cause_pkg::RESP_OKAY);
        pulse(4);
        rd_chk(reset_cause_pkg::OFF_STATUS, {24'h0, exp_status(8'hc2, 4)}, 2'b00);
        // second power-on in mid-run
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(reset_cause_pkg::OFF_STATUS, 32'h3d, reset_cause_pkg::RESP_OKAY);
        rd_chk(reset_cause_pkg::OFF_IRQ_MASK, 32'h0, reset_cause_pkg::RESP_OKAY);
        check(irq, 1'b0);
        report_and_stop;
    end

endmodule
